// [logic/swc_sysctl.sv]
// system control: watchdog, wakeup gating, low-voltage control, periodic wake
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module swc_sysctl #(
  parameter int TICK_1K_CYCLES = swc_pkg::TICK_1K_CYCLES,
  parameter int FAST_DIV       = swc_pkg::FAST_DIV
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        por_event,
  input  wire logic        pin_reset_event,
  input  wire logic        low_voltage_pin,
  input  wire logic        clk_32k_pin,
  input  wire logic        debug_mode,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  input  wire logic        keyboard_wakeup_flag,
  input  wire logic        analog_comparator_flag,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             system_reset_req,
  output logic             cpu_wakeup,
  output logic             lv_irq_req,
  output logic             periodic_irq_req,
  output logic             lv_detector_on
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]                   reset_cause;
    logic [7:0]                   sys_options;
    logic                         opt_written;
    logic [5:0]                   power_ctrl;
    logic                         lv_event_flag;
    logic                         periodic_clock_select;
    logic                         periodic_irq_enable;
    logic [2:0]                   periodic_rate_select;
    logic                         periodic_flag;
    logic [swc_pkg::WK_N-1:0]     wake_enable;
    logic [swc_pkg::WD_CNT_W-1:0] watchdog_counter;
    logic [swc_pkg::PER_CNT_W-1:0] per_cnt;
    logic                         stop_d;
    logic                         lv_hold;
    logic [2:0]                   rst_cnt;
    logic                         sys_rst;
    logic                         wake;
    logic                         lv_irq;
    logic                         per_irq;
    logic                         lv_on;
    logic [31:0]                  rdata;
    logic                         ready;
    logic                         wd_cause;
    logic                         lv_cause;
  } swc_state_s;

  swc_state_s st_reg;
  swc_state_s st_next;

  logic       lv_low;
  logic       clk32_s;
  logic       clk32_d;
  logic       tick_1k;
  logic       tick_fast;
  logic       slow_fast_tick;

  swc_sync2 #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d_async ({low_voltage_pin, clk_32k_pin}),
    .q_sync  ({lv_low, clk32_s})
  );

  // 1 kHz reference always free-running inside the control logic
  swc_tick_div #(.DIV(TICK_1K_CYCLES)) u_div_1k (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .run     (1'b1),
    .step    (1'b1),
    .tick    (tick_1k)
  );

  // trimmed source: count 32 rising edges of the synchronised 32 kHz pin
  swc_tick_div #(.DIV(FAST_DIV)) u_div_32 (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .run     (1'b1),
    .step    (clk32_s & ~clk32_d),
    .tick    (tick_fast)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clk32_d <= 1'b0;
    end else begin
      clk32_d <= clk32_s;
    end
  end

  function automatic logic [swc_pkg::PER_CNT_W-1:0] rate_period(
    input logic [2:0] rate
  );
    // periods of 8, 32, 64, 128, 256, 512 and 1024 ticks
    unique case (rate)
      3'h1:    rate_period = 11'h008;
      3'h2:    rate_period = 11'h020;
      3'h3:    rate_period = 11'h040;
      3'h4:    rate_period = 11'h080;
      3'h5:    rate_period = 11'h100;
      3'h6:    rate_period = 11'h200;
      3'h7:    rate_period = 11'h400;
      default: rate_period = 11'h000;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic                          acc;
  logic                          wr;
  logic                          in_stop;
  logic                          lv_running;
  logic                          per_tick;
  logic [swc_pkg::WD_CNT_W-1:0]  wd_limit;
  logic [swc_pkg::WK_N-1:0]      pending;
  logic [swc_pkg::WK_N-1:0]      sources;

  assign acc = psel & penable;
  assign wr  = acc & pwrite & pstrb[0];
  assign in_stop = stop_mode;
  assign lv_running = st_reg.power_ctrl[swc_pkg::PM_LV_EN] &
                      (~in_stop | st_reg.power_ctrl[swc_pkg::PM_LV_STOP]);
  assign per_tick = st_reg.periodic_clock_select ? tick_fast : tick_1k;
  assign wd_limit = st_reg.sys_options[swc_pkg::SO_WD_TIMEOUT] ?
                    9'(1 << swc_pkg::WD_LONG_LOG2) :
                    9'(1 << swc_pkg::WD_SHORT_LOG2);
  assign sources = {analog_comparator_flag, keyboard_wakeup_flag,
                    st_reg.periodic_flag, st_reg.lv_event_flag};
  // pending follows the live flags, so it drops with them
  assign pending = sources & st_reg.wake_enable;

  always_comb begin
    st_next = st_reg;
    st_next.stop_d = in_stop;
    st_next.ready = acc & ~st_reg.ready;
    st_next.lv_on = lv_running;
    // watchdog counter
    if (tick_1k && !debug_mode && !in_stop) begin
      st_next.watchdog_counter = st_reg.watchdog_counter + 9'h1;
    end
    if (in_stop && !st_reg.stop_d) begin
      st_next.watchdog_counter = '0;
    end
    // overflow only counts while enabled
    if (st_reg.sys_options[swc_pkg::SO_WD_ENABLE] &&
        st_reg.watchdog_counter >= wd_limit && !st_reg.sys_rst) begin
      st_next.sys_rst  = 1'b1;
      st_next.rst_cnt  = 3'(swc_pkg::RST_PULSE_CYC);
      st_next.wd_cause = 1'b1;
    end
    // low voltage: reset mode holds until supply recovers
    if (lv_running && lv_low &&
        st_reg.power_ctrl[swc_pkg::PM_LV_RST_EN]) begin
      st_next.lv_hold  = 1'b1;
      st_next.sys_rst  = 1'b1;
      st_next.lv_cause = 1'b1;
    end else if (st_reg.lv_hold && !lv_low) begin
      st_next.lv_hold = 1'b0;
      st_next.rst_cnt = 3'(swc_pkg::RST_PULSE_CYC);
    end
    if (st_reg.sys_rst && !st_reg.lv_hold && !st_next.lv_hold) begin
      if (st_reg.rst_cnt == 3'h0) begin
        st_next.sys_rst = 1'b0;
        // system reset done: restore options, power control and watchdog counter defaults and latch cause
        st_next.reset_cause = 8'h00;
        st_next.reset_cause[swc_pkg::RC_WDOG] = st_reg.wd_cause;
        st_next.reset_cause[swc_pkg::RC_LV] = st_reg.lv_cause;
        st_next.sys_options = swc_pkg::SO_RESET;
        st_next.opt_written = 1'b0;
        st_next.watchdog_counter = '0;
        st_next.power_ctrl = swc_pkg::PM_RESET[5:0];
        st_next.wd_cause = 1'b0;
        st_next.lv_cause = 1'b0;
      end else begin
        st_next.rst_cnt = st_reg.rst_cnt - 3'h1;
      end
    end
    // cause capture for external reset sources
    if (por_event) begin
      st_next.reset_cause = 8'h00;
      st_next.reset_cause[swc_pkg::RC_POR] = 1'b1;
      st_next.reset_cause[swc_pkg::RC_LV]  = 1'b1;
    end else if (pin_reset_event) begin
      st_next.reset_cause = 8'h00;
      st_next.reset_cause[swc_pkg::RC_PIN] = 1'b1;
    end
    // low-voltage interrupt flag; set wins over ack
    if (lv_running && lv_low &&
        st_reg.power_ctrl[swc_pkg::PM_LV_IRQ_EN] &&
        !st_reg.power_ctrl[swc_pkg::PM_LV_RST_EN]) begin
      st_next.lv_event_flag = 1'b1;
    end else if (wr && hit(paddr, swc_pkg::OFF_POWER_CTRL) &&
                 pwdata[swc_pkg::PM_LV_ACK]) begin
      st_next.lv_event_flag = 1'b0;
    end
    // periodic wakeup timer runs in every mode
    if (st_reg.periodic_rate_select == 3'h0) begin
      st_next.per_cnt = '0;
    end else if (per_tick) begin
      if (st_reg.per_cnt + 11'h1 >= rate_period(st_reg.periodic_rate_select))
      begin
        st_next.per_cnt = '0;
        st_next.periodic_flag = 1'b1;
      end else begin
        st_next.per_cnt = st_reg.per_cnt + 11'h1;
      end
    end
    if (wr && hit(paddr, swc_pkg::OFF_PERIODIC) && pwdata[swc_pkg::PW_ACK]
        && !st_next.periodic_flag) begin
      st_next.periodic_flag = 1'b0;
    end else if (wr && hit(paddr, swc_pkg::OFF_PERIODIC) &&
                 pwdata[swc_pkg::PW_ACK] && st_reg.periodic_flag &&
                 !(per_tick && st_reg.periodic_rate_select != 3'h0 &&
                   st_reg.per_cnt + 11'h1 >=
                   rate_period(st_reg.periodic_rate_select))) begin
      st_next.periodic_flag = 1'b0;
    end
    // register writes in the access phase
    if (wr && !st_reg.ready) begin
      unique case (paddr)
        swc_pkg::OFF_RESET_CAUSE: begin
          st_next.watchdog_counter = '0;
        end
        swc_pkg::OFF_SYS_OPTIONS: begin
          if (!st_reg.opt_written) begin
            st_next.sys_options = pwdata[7:0] & swc_pkg::SO_RESET;
            st_next.opt_written = 1'b1;
            st_next.watchdog_counter = '0;
          end
        end
        swc_pkg::OFF_POWER_CTRL: begin
          st_next.power_ctrl[5:2] = pwdata[5:2];
        end
        swc_pkg::OFF_PERIODIC: begin
          st_next.periodic_clock_select = pwdata[swc_pkg::PW_CLKSEL];
          st_next.periodic_irq_enable = pwdata[swc_pkg::PW_IRQ_EN];
          st_next.periodic_rate_select = pwdata[2:0];
        end
        swc_pkg::OFF_WAKE_ENABLE: begin
          st_next.wake_enable = pwdata[swc_pkg::WK_N-1:0];
        end
        default: begin
          st_next.rdata = st_reg.rdata; // pending is read-only
        end
      endcase
    end
    // reads
    st_next.rdata = 32'h0;
    if (acc && !pwrite) begin
      unique case (paddr)
        swc_pkg::OFF_RESET_CAUSE: st_next.rdata = {24'h0, st_reg.reset_cause};
        swc_pkg::OFF_SYS_OPTIONS: st_next.rdata = {24'h0, st_reg.sys_options};
        swc_pkg::OFF_WAKE_PEND:   st_next.rdata = {28'h0, pending};
        swc_pkg::OFF_POWER_CTRL:
          st_next.rdata = {24'h0, st_reg.lv_event_flag, 1'b0,
                           st_reg.power_ctrl[5:2], 2'h0};
        swc_pkg::OFF_PERIODIC:
          st_next.rdata = {24'h0, st_reg.periodic_flag, 1'b0,
                           st_reg.periodic_clock_select,
                           st_reg.periodic_irq_enable, 1'b0,
                           st_reg.periodic_rate_select};
        swc_pkg::OFF_WAKE_ENABLE: st_next.rdata = {28'h0, st_reg.wake_enable};
        default:                  st_next.rdata = 32'h0;
      endcase
    end
    // no dispatch: requests only wake the core
    st_next.wake = (|pending) & (wait_mode | stop_mode);
    st_next.lv_irq = st_reg.lv_event_flag &
                     st_reg.power_ctrl[swc_pkg::PM_LV_IRQ_EN];
    st_next.per_irq = st_reg.periodic_flag &
                      st_reg.periodic_irq_enable;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.sys_options <= swc_pkg::SO_RESET;
      st_reg.power_ctrl <= swc_pkg::PM_RESET[5:0];
      st_reg.reset_cause <= 8'h82;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata  = st_reg.rdata;
  assign pready  = st_reg.ready;
  assign pslverr = 1'b0;
  assign system_reset_req = st_reg.sys_rst;
  assign cpu_wakeup = st_reg.wake;
  assign lv_irq_req = st_reg.lv_irq;
  assign periodic_irq_req = st_reg.per_irq;
  assign lv_detector_on = st_reg.lv_on;

  ////////////////////////////////////////////////////////////////////////////
  property p_wd_clear;
    @(posedge clk_sys) disable iff (!reset_n)
      (wr && !st_reg.ready && paddr == swc_pkg::OFF_RESET_CAUSE && !tick_1k)
      |=> st_reg.watchdog_counter == '0;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("wd not cleared");
  // the release cycle still sees a full counter, so it is left out
  property p_wd_overflow;
    @(posedge clk_sys) disable iff (!reset_n)
      (st_reg.sys_options[swc_pkg::SO_WD_ENABLE] && !st_reg.sys_rst &&
       st_reg.watchdog_counter >= wd_limit)
      |=> st_reg.sys_rst;
  endproperty
  a_wd_overflow: assert property (p_wd_overflow)
    else $error("no wd reset");
  property p_wd_disabled;
    @(posedge clk_sys) disable iff (!reset_n)
      (!st_reg.sys_options[swc_pkg::SO_WD_ENABLE] && !st_reg.sys_rst &&
       !lv_low)
      |=> !st_reg.wd_cause;
  endproperty
  a_wd_disabled: assert property (p_wd_disabled)
    else $error("wd when off");
  property p_debug_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      (debug_mode && !wr && !st_reg.sys_rst && !(in_stop && !st_reg.stop_d))
      |=> st_reg.watchdog_counter == $past(st_reg.watchdog_counter);
  endproperty
  a_debug_hold: assert property (p_debug_hold)
    else $error("wd moved");
  property p_stop_entry;
    @(posedge clk_sys) disable iff (!reset_n)
      (in_stop && !st_reg.stop_d && !st_reg.sys_rst)
      |=> st_reg.watchdog_counter == '0;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop no zero");
  property p_opt_once;
    @(posedge clk_sys) disable iff (!reset_n)
      (st_reg.opt_written && !st_reg.sys_rst)
      |=> st_reg.sys_options == $past(st_reg.sys_options);
  endproperty
  a_opt_once: assert property (p_opt_once)
    else $error("options changed");
  property p_lv_off;
    @(posedge clk_sys) disable iff (!reset_n)
      (in_stop && !st_reg.power_ctrl[swc_pkg::PM_LV_STOP]) |=> !st_reg.lv_on;
  endproperty
  a_lv_off: assert property (p_lv_off)
    else $error("lv on in stop");
  property p_per_mask;
    @(posedge clk_sys) disable iff (!reset_n)
      !st_reg.periodic_irq_enable |=> !st_reg.per_irq;
  endproperty
  a_per_mask: assert property (p_per_mask)
    else $error("irq unmasked");
endmodule

// [pkg/swc_pkg.sv]
// package: register map, field positions, reset values and timing counts
package swc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_RESET_CAUSE  = 8'h00;
  localparam logic [7:0] OFF_SYS_OPTIONS  = 8'h04;
  localparam logic [7:0] OFF_WAKE_PEND    = 8'h08;
  localparam logic [7:0] OFF_POWER_CTRL   = 8'h0C;
  localparam logic [7:0] OFF_PERIODIC     = 8'h10;
  localparam logic [7:0] OFF_WAKE_ENABLE  = 8'h14;
  // reset-cause fields
  localparam int RC_POR  = 7;
  localparam int RC_PIN  = 6;
  localparam int RC_WDOG = 5;
  localparam int RC_LV   = 1;
  // system options fields
  localparam int SO_WD_ENABLE  = 7;
  localparam int SO_WD_TIMEOUT = 6;
  localparam logic [7:0] SO_RESET = 8'hC0;
  // power management fields
  localparam int PM_LV_FLAG   = 7;
  localparam int PM_LV_ACK    = 6;
  localparam int PM_LV_IRQ_EN = 5;
  localparam int PM_LV_RST_EN = 4;
  localparam int PM_LV_STOP   = 3;
  localparam int PM_LV_EN     = 2;
  localparam logic [7:0] PM_RESET = 8'h1C;
  // periodic wakeup control fields
  localparam int PW_FLAG   = 7;
  localparam int PW_ACK    = 6;
  localparam int PW_CLKSEL = 5;
  localparam int PW_IRQ_EN = 4;
  localparam int PW_RATE_LSB = 0;
  // wakeup pending / enable bit positions
  localparam int WK_LV   = 0;
  localparam int WK_PER  = 1;
  localparam int WK_KBD  = 2;
  localparam int WK_CMP  = 3;
  localparam int WK_N    = 4;
  // timing
  localparam int CLK_MHZ         = 200;
  localparam int TICK_1K_US      = 1000;
  localparam int TICK_1K_CYCLES  = TICK_1K_US * CLK_MHZ;
  localparam int FAST_DIV        = 32;
  localparam int WD_SHORT_LOG2   = 5;
  localparam int WD_LONG_LOG2    = 8;
  localparam int WD_CNT_W        = 9;
  localparam int PER_CNT_W       = 11;
  localparam int RST_PULSE_CYC   = 4;
endpackage

// [logic/swc_tick_div.sv]
// divider: one-cycle enable pulse every DIV cycles with step high, held while step is low, cleared while run is low
`timescale 1ns/100ps
module swc_tick_div #(
  parameter int DIV = 200000
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic run,
  input  wire logic step,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } swc_div_s;

  swc_div_s st_reg;
  swc_div_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = 32'h0;
    end else if (step) begin
      if (st_reg.cnt == 32'(DIV - 1)) begin
        st_next.cnt = 32'h0;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule

// [logic/swc_sync2.sv]
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
module swc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } swc_sync_s;

  swc_sync_s st_reg;
  swc_sync_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = d_async;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_sync = st_reg.s2;
endmodule

// [dv/swc_cpu_model.sv]
// cpu core model: apb master issuing single register accesses
`timescale 1ns/100ps
module swc_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // opens with an edge so back-to-back calls never assign psel twice
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= wr ? 4'hF : 4'h0;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // released bus shows a changed pattern, never the old request
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// [dv/testbench.sv]
// testbench: register, watchdog, wakeup, detector and periodic checks
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  localparam int T = 20;
  logic        clk_sys, reset_n, por_event, pin_reset_event;
  logic        low_voltage_pin, debug_mode, stop_mode;
  logic        clk_32k_pin = 1'b0;
  logic        wait_mode, keyboard_wakeup_flag, analog_comparator_flag;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        system_reset_req, cpu_wakeup, lv_irq_req;
  logic        periodic_irq_req, lv_detector_on, rst_ok;
  logic [1:0]  div3 = 2'h0;
  logic [31:0] exp_q[$];
  int          errors, cmp_count, seed, i, n, tk;
  swc_sysctl #(.TICK_1K_CYCLES(T), .FAST_DIV(32)) u_swc_sysctl (
    .clk_sys(clk_sys), .reset_n(reset_n), .por_event(por_event),
    .pin_reset_event(pin_reset_event), .low_voltage_pin(low_voltage_pin),
    .clk_32k_pin(clk_32k_pin), .debug_mode(debug_mode),
    .stop_mode(stop_mode), .wait_mode(wait_mode),
    .keyboard_wakeup_flag(keyboard_wakeup_flag),
    .analog_comparator_flag(analog_comparator_flag), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_reset_req(system_reset_req), .cpu_wakeup(cpu_wakeup),
    .lv_irq_req(lv_irq_req), .periodic_irq_req(periodic_irq_req),
    .lv_detector_on(lv_detector_on));
  swc_cpu_model u_swc_cpu_model (
    .clk_sys(clk_sys), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // 32 kHz stand-in: period of six system cycles, so 192 cycles a tick
  always @(posedge clk_sys) begin
    div3 <= (div3 == 2'h2) ? 2'h0 : div3 + 2'h1;
    if (div3 == 2'h2) clk_32k_pin <= ~clk_32k_pin;
  end
  // read results checked at the edge that takes them
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
      `CHK(pslverr, 1'b0)
      if (!pwrite && exp_q.size() > 0) `CHK(prdata, exp_q.pop_front())
    end
    if (!rst_ok) `CHK(system_reset_req, 1'b0)
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_swc_cpu_model.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_swc_cpu_model.xfer(1'b0, a, 32'h0);
  endtask
  task automatic ticks(input int k);
    repeat (k * T) @(posedge clk_sys);
  endtask
  // bounded wait; n holds the cycles taken
  task automatic wait_hi(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic test_done;
    $display("TB: errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys);
    errors++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 54;
    errors = 0;
    cmp_count = 0;
    rst_ok = 1'b1;
    {reset_n, por_event, pin_reset_event, low_voltage_pin} = 4'h0;
    {debug_mode, stop_mode, wait_mode} = 3'h0;
    {keyboard_wakeup_flag, analog_comparator_flag} = 2'h0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    rst_ok  <= 1'b0;
    rd(swc_pkg::OFF_RESET_CAUSE, 32'h82);
    rd(swc_pkg::OFF_SYS_OPTIONS, 32'hC0);
    rd(swc_pkg::OFF_POWER_CTRL, 32'h1C);
    wr(swc_pkg::OFF_WAKE_PEND, $random(seed));
    rd(swc_pkg::OFF_WAKE_PEND, 32'h0);
    wr(swc_pkg::OFF_SYS_OPTIONS, 32'h80);
    wr(swc_pkg::OFF_SYS_OPTIONS, 32'h40);
    rd(swc_pkg::OFF_SYS_OPTIONS, 32'h80);
    for (i = 0; i < 6; i++) begin
      ticks(20);
      wr(swc_pkg::OFF_RESET_CAUSE, $random(seed));
    end
    rd(swc_pkg::OFF_RESET_CAUSE, 32'h82);
    debug_mode <= 1'b1;
    ticks(60);
    debug_mode <= 1'b0;
    ticks(25);
    stop_mode <= 1'b1;
    ticks(60);
    stop_mode <= 1'b0;
    rst_ok <= 1'b1;
    wait_hi(system_reset_req);
    `CHK(n >= 31 * T && n <= 33 * T, 1'b1)
    repeat (16) @(posedge clk_sys);
    `CHK(system_reset_req, 1'b0)
    rst_ok <= 1'b0;
    rd(swc_pkg::OFF_RESET_CAUSE, 32'h20);
    rd(swc_pkg::OFF_SYS_OPTIONS, 32'hC0);
    wr(swc_pkg::OFF_SYS_OPTIONS, 32'h00);
    // wakeup gating: keyboard enabled, comparator left gated
    wr(swc_pkg::OFF_WAKE_ENABLE, 32'h4);
    wait_mode <= 1'b1;
    keyboard_wakeup_flag <= 1'b1;
    analog_comparator_flag <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(cpu_wakeup, 1'b1)
    rd(swc_pkg::OFF_WAKE_PEND, 32'h4);
    keyboard_wakeup_flag <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK(cpu_wakeup, 1'b0)
    rd(swc_pkg::OFF_WAKE_PEND, 32'h0);
    wait_mode <= 1'b0;
    analog_comparator_flag <= 1'b0;
    // detector in interrupt mode, then off in stop without keep
    wr(swc_pkg::OFF_POWER_CTRL, 32'h24);
    low_voltage_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    `CHK(lv_irq_req, 1'b1)
    `CHK(lv_detector_on, 1'b1)
    low_voltage_pin <= 1'b0;
    rd(swc_pkg::OFF_POWER_CTRL, 32'hA4);
    wr(swc_pkg::OFF_POWER_CTRL, 32'h64);
    rd(swc_pkg::OFF_POWER_CTRL, 32'h24);
    `CHK(lv_irq_req, 1'b0)
    stop_mode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(lv_detector_on, 1'b0)
    stop_mode <= 1'b0;
    // periodic period from each clock source, event to event
    for (i = 0; i < 2; i++) begin
      tk = (i == 1) ? 192 : T;
      // request falls one edge after the ack lands, so let it settle
      wr(swc_pkg::OFF_PERIODIC, 32'h51 | (32'(i) << 5));
      repeat (2) @(posedge clk_sys);
      `CHK(periodic_irq_req, 1'b0)
      wait_hi(periodic_irq_req);
      wr(swc_pkg::OFF_PERIODIC, 32'h51 | (32'(i) << 5));
      repeat (2) @(posedge clk_sys);
      `CHK(periodic_irq_req, 1'b0)
      wait_hi(periodic_irq_req);
      `CHK(n >= 7 * tk && n <= 9 * tk, 1'b1)
    end
    wr(swc_pkg::OFF_PERIODIC, 32'h41);
    ticks(10);
    `CHK(periodic_irq_req, 1'b0)
    rd(swc_pkg::OFF_PERIODIC, 32'h81);
    wr(swc_pkg::OFF_PERIODIC, 32'h40);
    ticks(20);
    rd(swc_pkg::OFF_PERIODIC, 32'h00);
    ticks(300);
    // low-voltage reset holds until the supply recovers
    wr(swc_pkg::OFF_POWER_CTRL, 32'h14);
    rst_ok <= 1'b1;
    low_voltage_pin <= 1'b1;
    repeat (40) @(posedge clk_sys);
    `CHK(system_reset_req, 1'b1)
    low_voltage_pin <= 1'b0;
    repeat (16) @(posedge clk_sys);
    `CHK(system_reset_req, 1'b0)
    rst_ok <= 1'b0;
    rd(swc_pkg::OFF_RESET_CAUSE, 32'h02);
    // external cause strobes overwrite the cause register
    pin_reset_event <= 1'b1;
    @(posedge clk_sys);
    pin_reset_event <= 1'b0;
    rd(swc_pkg::OFF_RESET_CAUSE, 32'h40);
    por_event <= 1'b1;
    @(posedge clk_sys);
    por_event <= 1'b0;
    rd(swc_pkg::OFF_RESET_CAUSE, 32'h82);
    test_done();
  end
endmodule
